// ===== epc_consts.vh
// Operation
// RULE1: Part holds 262,144 bytes, 18 address lines.
// RULE2: Data lines float when gate or select high.
// RULE3: Strobe high in reads, 2 us margin.
// RULE4: Erased cells read as all ones.
// RULE5: Programming only writes zeros into ones.
// RULE6: Address, data, core supply, then program supply.
// RULE7: Byte program: select low, gate high, 0.1 ms.
// RULE8: Gate low after pulse to verify byte.
// RULE9: Retry mismatching byte, at most ten pulses.
// RULE10: Ten failed byte pulses flag device failure.
// RULE11: Lower both supplies, then read back everything. Supply-down only lowers them; the testbench then reads back three bytes.
// RULE12: Page: four gate pulses latch four bytes.
// RULE13: Each page latch gate pulse lasts 1 us.
// RULE14: Select and gate high, then 0.1 ms pulse.
// RULE15: Verify four bytes, retry page up to ten.
// RULE16: Ten failed page pulses reject the device.
// RULE17: Part drives data when selected, gated, strobe high.
// RULE18: Part writes only under low strobe, program level.
`ifndef EPC_CONSTS_VH
`define EPC_CONSTS_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define EPC_CLK_NS        100
`define EPC_T_SETUP_NS    2000
`define EPC_T_LATCH_NS    1000
`define EPC_T_PULSE_NS    100000
`define EPC_SETUP_CYC     ((`EPC_T_SETUP_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_LATCH_CYC     ((`EPC_T_LATCH_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_PULSE_CYC     (`EPC_T_PULSE_NS / `EPC_CLK_NS)
`define EPC_MAX_TRIES     4'ha

// ----------------------------------------------------------------------------
// Command codes and widths
// ----------------------------------------------------------------------------
`define EPC_OP_READ       3'h0
`define EPC_OP_SUPPLY_UP  3'h1
`define EPC_OP_BYTE       3'h2
`define EPC_OP_PAGE       3'h3
`define EPC_OP_SUPPLY_DN  3'h4
`define EPC_ADDR_W        18
`define EPC_ERASED_BYTE   8'hff

`endif

// ===== epc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "epc_consts.vh"

module epc_ctrl
(
  input  wire        clk,
  input  wire        rst,
  input  wire        cmd_valid,
  input  wire [2:0]  cmd_op,
  input  wire [17:0] cmd_addr,
  input  wire [31:0] cmd_data,
  output wire        cmd_ready,
  output reg         done_valid,
  output reg  [7:0]  done_data,
  output reg         done_fail,
  output reg  [17:0] address_lines,
  output reg         chip_select_n,
  output reg         output_gate_n,
  output reg         program_strobe_n,
  output reg  [7:0]  data_lines_o,
  output reg         data_lines_oe,
  input  wire [7:0]  data_lines_i,
  output reg         vcc_prog_en,
  output reg         vpp_prog_en
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [3:0] S_IDLE   = 4'h0;
  localparam [3:0] S_RDWAIT = 4'h1;
  localparam [3:0] S_VCC    = 4'h2;
  localparam [3:0] S_VPP    = 4'h3;
  localparam [3:0] S_VDN    = 4'h4;
  localparam [3:0] S_LSETUP = 4'h5;
  localparam [3:0] S_LLOW   = 4'h6;
  localparam [3:0] S_LHIGH  = 4'h7;
  localparam [3:0] S_SETUP  = 4'h8;
  localparam [3:0] S_PULSE  = 4'h9;
  localparam [3:0] S_RECOV  = 4'ha;
  localparam [3:0] S_VFY    = 4'hb;
  localparam [3:0] S_FIN    = 4'hc;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // A state that loads cyc(n) lasts exactly n clock cycles.
  function [10:0] cyc;
    input [31:0] n;
    begin
      cyc = n[10:0] - 11'h001;
    end
  endfunction

  // Picks byte idx of a page word, byte 0 in the low lane.
  function [7:0] byte_sel;
    input [31:0] w;
    input [1:0]  idx;
    begin
      byte_sel = w[8 * idx +: 8];
    end
  endfunction

  reg [3:0]  state_q;
  reg [2:0]  op_q;
  reg [17:0] base_q;
  reg [31:0] wdata_q;
  reg [3:0]  tries_q;
  reg [1:0]  bidx_q;
  reg        mism_q;
  reg [10:0] tmr_q;
  reg [7:0]  sync1_q;
  reg [7:0]  sync2_q;
  reg [7:0]  sync3_q;
  reg [7:0]  rd_q;

  wire       tz      = (tmr_q == 11'h000);
  wire       is_page = (op_q == `EPC_OP_PAGE);
  wire [7:0] exp_b   = is_page ? byte_sel(wdata_q, bidx_q) : wdata_q[7:0];
  wire       bad_now = mism_q | (rd_q != exp_b);

  assign cmd_ready = (state_q == S_IDLE);

  // --------------------------------------------------------------------------
  // Read-back synchroniser
  // --------------------------------------------------------------------------

  // The part is asynchronous to us; a byte counts only once stages 2 and 3 agree.
  always @(posedge clk)
  begin
    if (rst)
    begin
      sync1_q <= `EPC_ERASED_BYTE;
      sync2_q <= `EPC_ERASED_BYTE;
      sync3_q <= `EPC_ERASED_BYTE;
      rd_q    <= `EPC_ERASED_BYTE;
    end
    else
    begin
      sync1_q <= data_lines_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q)
        rd_q <= sync3_q;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------

  // Every phase waits on one shared timer; each wait but the 1 us latch pulse is at least 2 us, which
  // covers all setup and hold figures and the data-settle time at once.
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q          <= S_IDLE;
      op_q             <= `EPC_OP_READ;
      base_q           <= 18'h00000;
      wdata_q          <= 32'hffffffff;
      tries_q          <= 4'h0;
      bidx_q           <= 2'h0;
      mism_q           <= 1'b0;
      tmr_q            <= 11'h000;
      done_valid       <= 1'b0;
      done_data        <= 8'h00;
      done_fail        <= 1'b0;
      address_lines    <= 18'h00000;
      chip_select_n    <= 1'b1;
      output_gate_n    <= 1'b1;
      program_strobe_n <= 1'b1;
      data_lines_o     <= 8'h00;
      data_lines_oe    <= 1'b0;
      vcc_prog_en      <= 1'b0;
      vpp_prog_en      <= 1'b0;
    end
    else
    begin
      done_valid <= 1'b0;
      if (!tz)
        tmr_q <= tmr_q - 11'h001;
      case (state_q)
        S_IDLE:
        begin
          if (cmd_valid)
          begin
            op_q          <= cmd_op;
            wdata_q       <= cmd_data;
            tries_q       <= 4'h0;
            bidx_q        <= 2'h0;
            mism_q        <= 1'b0;
            done_fail     <= 1'b0;
            base_q        <= cmd_addr;
            address_lines <= cmd_addr;                  // RULE1
            data_lines_o  <= cmd_data[7:0];
            tmr_q         <= cyc(`EPC_SETUP_CYC);
            case (cmd_op)
              `EPC_OP_READ:
              begin
                // Strobe stays high for the whole read.
                chip_select_n <= 1'b0;                  // RULE3
                output_gate_n <= 1'b0;
                data_lines_oe <= 1'b0;
                state_q       <= S_RDWAIT;
              end
              `EPC_OP_SUPPLY_UP:
              begin
                data_lines_oe <= 1'b1;                  // RULE6
                state_q       <= S_VCC;
              end
              `EPC_OP_SUPPLY_DN:
              begin
                data_lines_oe <= 1'b0;
                vpp_prog_en   <= 1'b0;                  // RULE11
                state_q       <= S_VDN;
              end
              `EPC_OP_BYTE:
              begin
                chip_select_n <= 1'b0;                  // RULE7
                output_gate_n <= 1'b1;
                data_lines_oe <= 1'b1;                  // RULE5
                state_q       <= S_SETUP;
              end
              `EPC_OP_PAGE:
              begin
                base_q        <= {cmd_addr[17:2], 2'b00};
                address_lines <= {cmd_addr[17:2], 2'b00};
                chip_select_n <= 1'b1;                  // RULE12
                data_lines_oe <= 1'b1;
                state_q       <= S_LSETUP;
              end
              default:
              begin
                // Unknown codes are answered as a failure after the 2 us wait in S_FIN.
                done_fail <= 1'b1;
                state_q   <= S_FIN;
              end
            endcase
          end
        end
        S_RDWAIT:
        begin
          if (tz)
          begin
            done_data     <= rd_q;
            done_valid    <= 1'b1;
            chip_select_n <= 1'b1;                      // RULE2
            output_gate_n <= 1'b1;
            state_q       <= S_IDLE;
          end
        end
        S_VCC:
        begin
          if (tz)
          begin
            vcc_prog_en <= 1'b1;                        // RULE6
            tmr_q       <= cyc(`EPC_SETUP_CYC);
            state_q     <= S_VPP;
          end
        end
        S_VPP:
        begin
          if (tz)
          begin
            vpp_prog_en <= 1'b1;                        // RULE6
            tmr_q       <= cyc(`EPC_SETUP_CYC);
            state_q     <= S_FIN;
          end
        end
        S_VDN:
        begin
          if (tz)
          begin
            vcc_prog_en <= 1'b0;                        // RULE11
            tmr_q       <= cyc(`EPC_SETUP_CYC);
            state_q     <= S_FIN;
          end
        end
        S_LSETUP:
        begin
          if (tz)
          begin
            output_gate_n <= 1'b0;                      // RULE12
            tmr_q         <= cyc(`EPC_LATCH_CYC);
            state_q       <= S_LLOW;
          end
        end
        S_LLOW:
        begin
          if (tz)
          begin
            output_gate_n <= 1'b1;                      // RULE13
            tmr_q         <= cyc(`EPC_SETUP_CYC);
            state_q       <= S_LHIGH;
          end
        end
        S_LHIGH:
        begin
          if (tz)
          begin
            tmr_q <= cyc(`EPC_SETUP_CYC);
            if (bidx_q == 2'h3)
            begin
              bidx_q        <= 2'h0;
              data_lines_oe <= 1'b0;
              state_q       <= S_SETUP;                 // RULE14
            end
            else
            begin
              bidx_q        <= bidx_q + 2'h1;
              address_lines <= base_q + {16'h0000, bidx_q + 2'h1};
              data_lines_o  <= byte_sel(wdata_q, bidx_q + 2'h1);
              state_q       <= S_LSETUP;
            end
          end
        end
        S_SETUP:
        begin
          if (tz)
          begin
            program_strobe_n <= 1'b0;                   // RULE7
            tries_q          <= tries_q + 4'h1;
            tmr_q            <= cyc(`EPC_PULSE_CYC);
            state_q          <= S_PULSE;
          end
        end
        S_PULSE:
        begin
          if (tz)
          begin
            // Float before the gate drops so the part and we never fight.
            program_strobe_n <= 1'b1;
            data_lines_oe    <= 1'b0;
            address_lines    <= base_q;
            bidx_q           <= 2'h0;
            mism_q           <= 1'b0;
            tmr_q            <= cyc(`EPC_SETUP_CYC);
            state_q          <= S_RECOV;
          end
        end
        S_RECOV:
        begin
          if (tz)
          begin
            chip_select_n <= 1'b0;                      // RULE8
            output_gate_n <= 1'b0;
            tmr_q         <= cyc(`EPC_SETUP_CYC);
            state_q       <= S_VFY;
          end
        end
        S_VFY:
        begin
          if (tz)
          begin
            done_data <= rd_q;
            tmr_q     <= cyc(`EPC_SETUP_CYC);
            if (is_page && (bidx_q != 2'h3))
            begin
              mism_q        <= bad_now;                 // RULE15
              bidx_q        <= bidx_q + 2'h1;
              address_lines <= base_q + {16'h0000, bidx_q + 2'h1};
            end
            else if (!bad_now)
            begin
              output_gate_n <= 1'b1;                    // RULE9
              state_q       <= S_FIN;
            end
            else if (tries_q == `EPC_MAX_TRIES)
            begin
              done_fail     <= 1'b1;                    // RULE10 RULE16
              output_gate_n <= 1'b1;
              state_q       <= S_FIN;
            end
            else
            begin
              // Retry: rebuild the pulse conditions; the page buffer keeps its data.
              output_gate_n <= 1'b1;                    // RULE9 RULE15
              address_lines <= base_q;
              bidx_q        <= 2'h0;
              chip_select_n <= is_page;                 // RULE14
              data_lines_o  <= wdata_q[7:0];
              data_lines_oe <= !is_page;
              state_q       <= S_SETUP;
            end
          end
        end
        S_FIN:
        begin
          if (tz)
          begin
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            done_valid    <= 1'b1;
            state_q       <= S_IDLE;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== epc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module epc_ctrl_chk
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic       cmd_ready,
  input wire logic       done_valid,
  input wire logic       chip_select_n,
  input wire logic       output_gate_n,
  input wire logic       program_strobe_n,
  input wire logic       data_lines_oe,
  input wire logic       vcc_prog_en,
  input wire logic       vpp_prog_en
);
  logic [10:0] low_cnt_q;
  logic [10:0] gate_cnt_q;
  logic [3:0]  fall_cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Low time of strobe and gate, and strobe pulses since the last command was taken.
  always @(posedge clk)
  begin
    if (rst || program_strobe_n)
      low_cnt_q <= 11'h0;
    else
      low_cnt_q <= low_cnt_q + 11'h1;
    if (rst || output_gate_n)
      gate_cnt_q <= 11'h0;
    else
      gate_cnt_q <= gate_cnt_q + 11'h1;
    if (rst || (cmd_valid && cmd_ready))
      fall_cnt_q <= 4'h0;
    else if (!program_strobe_n && low_cnt_q == 11'h0)
      fall_cnt_q <= fall_cnt_q + 4'h1;
  end
  property p_pulse_width;
    $rose(program_strobe_n) && !$past(rst) |-> low_cnt_q == 11'h3e8;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width");
  property p_byte_pins;
    !program_strobe_n && !chip_select_n |-> output_gate_n && data_lines_oe;
  endproperty
  a_byte_pins: assert property (p_byte_pins) else $error("byte pins");
  property p_page_pins;
    !program_strobe_n && chip_select_n |-> output_gate_n && !data_lines_oe;
  endproperty
  a_page_pins: assert property (p_page_pins) else $error("page pins");
  property p_read_strobe;
    !chip_select_n && !output_gate_n |-> program_strobe_n;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("strobe in read");
  property p_strobe_margin;
    $rose(output_gate_n) && !$past(rst) |-> $past(program_strobe_n, 20);
  endproperty
  a_strobe_margin: assert property (p_strobe_margin) else $error("strobe margin");
  property p_supply_order;
    $rose(vpp_prog_en) |-> $past(vcc_prog_en, 19);
  endproperty
  a_supply_order: assert property (p_supply_order) else $error("supply order");
  property p_latch_width;
    $rose(output_gate_n) && chip_select_n && !$past(rst) |-> gate_cnt_q >= 11'ha;
  endproperty
  a_latch_width: assert property (p_latch_width) else $error("latch width");
  property p_pulse_limit;
    fall_cnt_q <= 4'ha;
  endproperty
  a_pulse_limit: assert property (p_pulse_limit) else $error("pulse count");
  property p_read_answer;
    cmd_valid && cmd_ready && cmd_op == 3'h0 |-> ##[20:21] done_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer");
endmodule
bind epc_ctrl epc_ctrl_chk epc_ctrl_chk_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_ready(cmd_ready), .done_valid(done_valid), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
  .program_strobe_n(program_strobe_n), .data_lines_oe(data_lines_oe), .vcc_prog_en(vcc_prog_en),
  .vpp_prog_en(vpp_prog_en));
`default_nettype wire

// ===== epc_eprom_mdl.sv
`timescale 1ns/1ps
`default_nettype none
module epc_eprom_mdl
(
  input  wire logic [17:0] address_lines,
  input  wire logic        chip_select_n,
  input  wire logic        output_gate_n,
  input  wire logic        program_strobe_n,
  input  wire logic [7:0]  data_lines_o,
  input  wire logic        data_lines_oe,
  input  wire logic        vcc_prog_en,
  input  wire logic        vpp_prog_en,
  input  wire logic [3:0]  skip_pulses,
  output wire logic [7:0]  data_lines_i
);
  logic [7:0] mem [0:262143];
  logic [7:0] page [0:3];
  logic [7:0] last = 8'hff;
  logic [3:0] seen = 4'h0;
  wire        drv = !chip_select_n && !output_gate_n && program_strobe_n;
  wire        hot = vcc_prog_en && vpp_prog_en;
  integer     i;
  // Parts ship erased.
  initial
  begin
    for (i = 0; i < 262144; i++)
      mem[i] = 8'hff;
  end
  // A released line shows the inverse of its last value, so stale data never passes a verify.
  assign data_lines_i = data_lines_oe ? data_lines_o : drv ? mem[address_lines] : ~last;
  always @*
    if (drv)
      last = mem[address_lines];
  always @(skip_pulses)
    seen = 4'h0;
  // Page latch with select and strobe high.
  always @(negedge output_gate_n)
    if (hot && chip_select_n && program_strobe_n)
      page[address_lines[1:0]] = data_lines_o;
  // Pulses only clear bits; skipped pulses mimic a slow cell.
  always @(negedge program_strobe_n)
    if (hot && output_gate_n)
    begin
      if (seen < skip_pulses)
        seen = seen + 4'h1;
      else if (!chip_select_n)
        mem[address_lines] = mem[address_lines] & data_lines_o;
      else
        for (i = 0; i < 4; i++)
          mem[{address_lines[17:2], i[1:0]}] &= page[i];
    end
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin $display("wrong value %s exp %h got %h", n, e, g); err_total++; end end
module tb;
  typedef struct packed {logic [2:0] op; logic [17:0] a; logic [31:0] d; logic [7:0] e; logic f; logic c;} epc_row_t;
  logic        clk, rst, cmd_valid, cmd_ready, done_valid, done_fail;
  logic        chip_select_n, output_gate_n, program_strobe_n, data_lines_oe, vcc_prog_en, vpp_prog_en;
  logic [2:0]  cmd_op;
  logic [17:0] cmd_addr, address_lines;
  logic [31:0] cmd_data;
  logic [7:0]  done_data, data_lines_o, data_lines_i;
  logic [3:0]  skip_pulses;
  integer      err_total, comparisons, pulses, k;
  epc_row_t    rows [0:8];
  epc_ctrl epc_ctrl_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done_valid(done_valid), .done_data(done_data),
    .done_fail(done_fail), .address_lines(address_lines), .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n), .program_strobe_n(program_strobe_n), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i), .vcc_prog_en(vcc_prog_en),
    .vpp_prog_en(vpp_prog_en));
  epc_eprom_mdl epc_eprom_mdl_i (.address_lines(address_lines), .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n), .program_strobe_n(program_strobe_n), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe), .vcc_prog_en(vcc_prog_en), .vpp_prog_en(vpp_prog_en),
    .skip_pulses(skip_pulses), .data_lines_i(data_lines_i));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge program_strobe_n)
    pulses++;
  task automatic give_verdict;
    begin
      if (err_total == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // One command, waited for under a bound, then its answer compared.
  task automatic run(input epc_row_t r);
    integer n;
    begin
      n = 0;
      cmd_op <= r.op;
      cmd_addr <= r.a;
      cmd_data <= r.d;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      while (done_valid !== 1'b1 && n < 20000)
      begin
        @(posedge clk);
        n++;
      end
      // A command that never answers counts as a mismatch.
      if (n >= 20000)
        err_total++;
      `CHK("fail", r.f, done_fail)
      if (r.c)
        `CHK("data", r.e, done_data)
    end
  endtask
  // Watchdog: about twice the expected run.
  initial
  begin
    #6000000;
    err_total++;
    give_verdict();
  end
  initial
  begin
    {rst, cmd_valid, cmd_op, cmd_addr, cmd_data, skip_pulses} = {1'b1, 1'b0, 3'h0, 18'h0, 32'h0, 4'h0};
    {err_total, comparisons, pulses} = {32'h0, 32'h0, 32'h0};
    rows = '{'{3'h0, 18'h5, 32'h0, 8'hff, 1'b0, 1'b1}, '{3'h7, 18'h0, 32'h0, 8'h0, 1'b1, 1'b0},
      '{3'h1, 18'h5, 32'ha5, 8'h0, 1'b0, 1'b0}, '{3'h2, 18'h5, 32'ha5, 8'ha5, 1'b0, 1'b1},
      '{3'h3, 18'h11, 32'h44332211, 8'h0, 1'b0, 1'b0}, '{3'h4, 18'h0, 32'h0, 8'h0, 1'b0, 1'b0},
      '{3'h0, 18'h5, 32'h0, 8'ha5, 1'b0, 1'b1}, '{3'h0, 18'h10, 32'h0, 8'h11, 1'b0, 1'b1},
      '{3'h0, 18'h13, 32'h0, 8'h44, 1'b0, 1'b1}};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 9; k++)
      run(rows[k]);
    run('{3'h1, 18'h6, 32'hf, 8'h0, 1'b0, 1'b0});
    // A slow cell takes three pulses.
    skip_pulses <= 4'h2;
    pulses = 0;
    run('{3'h2, 18'h6, 32'hf, 8'hf, 1'b0, 1'b1});
    `CHK("pulses", 3, pulses)
    // Setting a cleared bit back to one can never verify.
    skip_pulses <= 4'h0;
    pulses = 0;
    run('{3'h2, 18'h5, 32'hff, 8'ha5, 1'b1, 1'b1});
    `CHK("pulses", 10, pulses)
    skip_pulses <= 4'hf;
    pulses = 0;
    run('{3'h3, 18'h20, 32'h0, 8'h0, 1'b1, 1'b0});
    `CHK("pulses", 10, pulses)
    // Reset in the middle of a program pulse.
    skip_pulses <= 4'h0;
    cmd_op <= 3'h2;
    cmd_addr <= 18'h7;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (200) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("strobe", 1'b1, program_strobe_n)
    `CHK("vpp", 1'b0, vpp_prog_en)
    `CHK("vcc", 1'b0, vcc_prog_en)
    run('{3'h0, 18'h6, 32'h0, 8'hf, 1'b0, 1'b1});
    give_verdict();
  end
endmodule
`default_nettype wire
